/* File: rtl/lsfd_fwd_check.v */
// Purpose: Decide whether one store may forward to one load
// Assumes: Load lies inside the store; sizes are powers of two
// Notes: Pure combinational
`default_nettype none
module lsfd_fwd_check (
  input wire [5:0] st_size_in,
  input wire [5:0] ld_size_in,
  input wire [4:0] ofs_in,
  output reg ok_out
);
  reg [3:0] o16;
  reg [5:0] endb;
  always @* begin
    o16 = ofs_in[3:0];
    endb = {1'b0, ofs_in} + ld_size_in;
    ok_out = 1'b0;
    if (endb <= st_size_in) begin
      if (ld_size_in == 6'h01) begin
        ok_out = 1'b1;
      end else if (st_size_in <= 6'h08) begin
        // RL17 2-byte loads forward at any offset; 4-byte at offset 0-4 in an 8-byte store; others at offset 0
        if (ld_size_in == 6'h02) ok_out = 1'b1;
        else if (ld_size_in == 6'h04) ok_out = (st_size_in == 6'h08) ? (ofs_in <= 5'h04) : (ofs_in == 5'h00);
        else ok_out = (ofs_in == 5'h00);
      end else begin
        // RL16 halves handled alike
        if (ld_size_in == 6'h20) ok_out = (ofs_in == 5'h00);
        // RL15 no midpoint crossing
        else if (({2'b00, o16} + ld_size_in) > 6'h10) ok_out = 1'b0;
        // RL18 RL14 eight byte boundary
        else if (ld_size_in == 6'h10) ok_out = (o16 == 4'h0);
        else if (ld_size_in == 6'h08) ok_out = (o16[2:0] == 3'h0);
        else if (ld_size_in == 6'h04) ok_out = (o16[2:0] <= 3'h4);
        else ok_out = 1'b1;
      end
    end
  end
endmodule // lsfd_fwd_check
`default_nettype wire

/* File: rtl/lsfd_unit.v */
// Purpose: Load/store unit with store buffer, forwarding and disambiguation
// Assumes: One load issued per cycle into the check; store buffer in age order
// Notes: Store buffer allocates in program order and drains after retirement
`include "lsfd_defines.vh"
`default_nettype none
// Functional notes
// RL1 - speculative loads never fault nor touch uncacheable
// RL2 - integer load five cycles, four short offset
// RL3 - latency by data type and addressing
// RL4 - nonzero segment base adds latency
// RL5 - stores fill buffer, forward once complete
// RL6 - commit after retire, 16 bytes per cycle
// RL7 - three translations per cycle
// RL8 - first miss uses second level, seven cycles; code reports second-level hits in the same cycle as first-level hits
// RL9 - 4K, 2M/4M, 1G pages supported
// RL10 - four-way translation buffers with sizes
// RL11 - forward only from youngest older store
// RL12 - load must be inside store
// RL13 - write-back only, no non-temporal
// RL14 - no 4/8 load across eight bytes
// RL15 - no load across 32-byte store middle
// RL16 - 32-byte store acts as two halves
// RL17 - small stores: aligned wider loads only; code forwards 2-byte loads at any offset and 4-byte loads at offsets 0-4 of an 8-byte store
// RL18 - 16-byte store offset table
// RL19 - predictor lets independent loads proceed early
// RL20 - verify prediction, replay on conflict
// RL21 - split loads stall for all addresses
// RL22 - low 12 address bits match means dependent
// RL23 - refused overlap waits for store commit
module lsfd_unit (
  input wire clk_in,
  input wire sys_rst_in,
  input wire st_alloc_in,
  input wire st_addr_in,
  input wire [2:0] st_addr_idx_in,
  input wire [31:0] st_lin_in,
  input wire [31:0] st_phys_in,
  input wire [5:0] st_size_in,
  input wire st_nt_in,
  input wire st_data_in,
  input wire [2:0] st_data_idx_in,
  input wire [255:0] st_wdata_in,
  input wire st_retire_in,
  input wire ld_valid_in,
  input wire [31:0] ld_addr_in,
  input wire [5:0] ld_size_in,
  input wire [1:0] ld_type_in,
  input wire ld_short_in,
  input wire [11:0] ld_ofs_in,
  input wire ld_seg_nz_in,
  input wire ld_wb_in,
  input wire ld_nt_in,
  input wire ld_spec_in,
  input wire ld_fault_in,
  input wire ld_uc_in,
  input wire pred_indep_in,
  input wire [1:0] ld2_xlat_in,
  input wire [59:0] xlat_vpn_in,
  input wire fill_in,
  input wire [19:0] fill_vpn_in,
  input wire [1:0] fill_pg_in,
  output wire ld_ready_out,
  output reg ld_done_out,
  output reg ld_fwd_out,
  output reg [255:0] ld_data_out,
  output reg ld_fault_out,
  output reg ld_replay_out,
  output reg array_rd_out,
  output reg commit_out,
  output reg [31:0] commit_addr_out,
  output reg [127:0] commit_data_out,
  output reg [15:0] commit_be_out,
  output wire sb_full_out,
  output wire [2:0] xlat_hit_out,
  output wire [2:0] xlat_l2hit_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_LAT = 2'h2;
  reg [31:0] sb_lin [0:7];
  reg [31:0] sb_phys [0:7];
  reg [255:0] sb_data [0:7];
  reg [5:0] sb_size [0:7];
  reg [7:0] sb_val;
  reg [7:0] sb_av;
  reg [7:0] sb_dv;
  reg [7:0] sb_nt;
  reg [7:0] sb_ret;
  reg [2:0] head;
  reg [2:0] tail;
  reg [3:0] cnt;
  reg [5:0] commit_pos;
  reg [1:0] state;
  reg [3:0] lat;
  reg [31:0] l_addr;
  reg [5:0] l_size;
  reg l_fwd;
  reg l_spec_early;
  reg [2:0] l_src;
  reg [255:0] l_data;
  reg [3:0] next_lat;
  reg l_cw;
  reg l_flt;
  reg commit_last;
  wire [7:0] fwd_ok;
  reg [7:0] overlap;
  reg [7:0] contain;
  reg [7:0] unk_older;
  reg [7:0] pmatch;
  reg [2:0] youngest;
  reg any_ov;
  reg any_unk;
  reg any_pm;
  reg split;
  reg [2:0] k;
  integer i;
  integer j;
  genvar g;
  assign sb_full_out = (cnt == 4'h8);
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_fwd
      lsfd_fwd_check u_chk (
        .st_size_in(sb_size[g]),
        .ld_size_in(ld_size_in),
        .ofs_in(ld_addr_in[4:0] - sb_lin[g][4:0]),
        .ok_out(fwd_ok[g])
      );
    end
  endgenerate
  lsfd_xlat u_xlat (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .req_in({st_addr_in, ld2_xlat_in}),
    .vpn_in(xlat_vpn_in),
    .fill_in(fill_in),
    .fill_vpn_in(fill_vpn_in),
    .fill_pg_in(fill_pg_in),
    .hit_out(xlat_hit_out),
    .l2hit_out(xlat_l2hit_out)
  );
  // Scan stores oldest to youngest so the last match wins
  always @* begin
    overlap = 8'h00;
    contain = 8'h00;
    unk_older = 8'h00;
    pmatch = 8'h00;
    youngest = 3'h0;
    any_ov = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      k = head + i[2:0];
      if (sb_val[k]) begin
        unk_older[k] = ~sb_av[k];
        // RL22 low bits dependence
        pmatch[k] = sb_av[k] && (sb_lin[k][11:0] == ld_addr_in[11:0]);
        overlap[k] = sb_av[k] && (ld_addr_in < sb_lin[k] + {26'h0, sb_size[k]})
          && (sb_lin[k] < ld_addr_in + {26'h0, ld_size_in});
        // RL12 containment
        contain[k] = (ld_addr_in >= sb_lin[k])
          && (ld_addr_in + {26'h0, ld_size_in} <= sb_lin[k] + {26'h0, sb_size[k]});
        if (overlap[k] || pmatch[k]) begin
          // RL11 youngest older store
          youngest = k;
          any_ov = 1'b1;
        end
      end
    end
    any_unk = |unk_older;
    any_pm = |pmatch;
    // RL21 split or misaligned wide
    split = ({2'b00, ld_addr_in[3:0]} + ld_size_in > 6'h10) && !(ld_size_in == 6'h20 && ld_addr_in[4:0] == 5'h00);
    // RL2 RL3 base latency
    if (ld_type_in == `LSFD_DT_VEC256) next_lat = `LSFD_LAT_VEC256;
    else if (ld_type_in == `LSFD_DT_STACK) next_lat = `LSFD_LAT_STACK - {3'h0, ld_short_in && ld_ofs_in < `LSFD_SHORT_OFS};
    else if (ld_type_in == `LSFD_DT_VEC128) next_lat = `LSFD_LAT_VEC128 - {3'h0, ld_short_in && ld_ofs_in < `LSFD_SHORT_OFS};
    else next_lat = `LSFD_LAT_INT - {3'h0, ld_short_in && ld_ofs_in < `LSFD_SHORT_OFS};
    // RL4 segment penalty
    if (ld_seg_nz_in) next_lat = next_lat + `LSFD_LAT_SEG;
    // Head entry finishes its last commit beat this cycle
    commit_last = sb_val[head] && sb_ret[head] && sb_dv[head]
      && (commit_pos + `LSFD_COMMIT_BYTES >= sb_size[head]);
  end
  assign ld_ready_out = (state == ST_IDLE);
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      sb_val <= 8'h00;
      sb_av <= 8'h00;
      sb_dv <= 8'h00;
      sb_nt <= 8'h00;
      sb_ret <= 8'h00;
      head <= 3'h0;
      tail <= 3'h0;
      cnt <= 4'h0;
      commit_pos <= 6'h00;
      state <= ST_IDLE;
      lat <= 4'h0;
      l_addr <= 32'h0;
      l_size <= 6'h00;
      l_fwd <= 1'b0;
      l_spec_early <= 1'b0;
      l_cw <= 1'b0;
      l_flt <= 1'b0;
      l_src <= 3'h0;
      l_data <= 256'h0;
      ld_done_out <= 1'b0;
      ld_fwd_out <= 1'b0;
      ld_data_out <= 256'h0;
      ld_fault_out <= 1'b0;
      ld_replay_out <= 1'b0;
      array_rd_out <= 1'b0;
      commit_out <= 1'b0;
      commit_addr_out <= 32'h0;
      commit_data_out <= 128'h0;
      commit_be_out <= 16'h0000;
    end else begin
      ld_done_out <= 1'b0;
      ld_fault_out <= 1'b0;
      ld_replay_out <= 1'b0;
      array_rd_out <= 1'b0;
      commit_out <= 1'b0;
      ld_fwd_out <= 1'b0;
      // Occupancy counts allocations against finished commits
      if ((st_alloc_in && !sb_full_out) && !commit_last) begin
        cnt <= cnt + 4'h1;
      end else if (!(st_alloc_in && !sb_full_out) && commit_last) begin
        cnt <= cnt - 4'h1;
      end
      // RL5 execution phase fill
      if (st_alloc_in && !sb_full_out) begin
        sb_val[tail] <= 1'b1;
        sb_av[tail] <= 1'b0;
        sb_dv[tail] <= 1'b0;
        sb_ret[tail] <= 1'b0;
        tail <= tail + 3'h1;
      end
      if (st_addr_in) begin
        sb_av[st_addr_idx_in] <= 1'b1;
        sb_lin[st_addr_idx_in] <= st_lin_in;
        sb_phys[st_addr_idx_in] <= st_phys_in;
        sb_size[st_addr_idx_in] <= st_size_in;
        sb_nt[st_addr_idx_in] <= st_nt_in;
      end
      if (st_data_in) begin
        sb_dv[st_data_idx_in] <= 1'b1;
        sb_data[st_data_idx_in] <= st_wdata_in;
      end
      if (st_retire_in && sb_val[head]) begin
        sb_ret[head] <= 1'b1;
      end
      // RL6 commit after retire
      if (sb_val[head] && sb_ret[head] && sb_dv[head]) begin
        commit_out <= 1'b1;
        commit_addr_out <= sb_phys[head] + {26'h0, commit_pos};
        commit_data_out <= sb_data[head][commit_pos[4] * 128 +: 128];
        commit_be_out <= (sb_size[head] >= 6'h10) ? 16'hFFFF : ((16'h0001 << sb_size[head][4:0]) - 16'h0001);
        if (commit_pos + `LSFD_COMMIT_BYTES >= sb_size[head]) begin
          commit_pos <= 6'h00;
          sb_val[head] <= 1'b0;
          head <= head + 3'h1;
        end else begin
          commit_pos <= commit_pos + `LSFD_COMMIT_BYTES;
        end
      end
      case (state)
        ST_IDLE: begin
          if (ld_valid_in) begin
            l_addr <= ld_addr_in;
            l_size <= ld_size_in;
            lat <= next_lat - 4'h1;
            l_cw <= 1'b0;
            l_flt <= ld_fault_in;
            l_spec_early <= 1'b0;
            // RL1 suppress speculative faults
            if (ld_spec_in && (ld_uc_in || ld_fault_in)) begin
              state <= ST_WAIT;
            end else if (ld_fault_in) begin
              ld_fault_out <= 1'b1;
            end else if (split && any_unk) begin
              state <= ST_WAIT;
            // RL13 memory type gate
            end else if (any_ov && fwd_ok[youngest] && contain[youngest] && sb_dv[youngest]
              && ld_wb_in && !ld_nt_in && !sb_nt[youngest] && !ld_uc_in) begin
              l_fwd <= 1'b1;
              l_data <= sb_data[youngest] >> {ld_addr_in[4:0] - sb_lin[youngest][4:0], 3'h0};
              state <= ST_LAT;
            // RL23 wait for commit
            end else if (any_ov) begin
              l_src <= youngest;
              l_cw <= 1'b1;
              state <= ST_WAIT;
            // RL19 predicted independent
            end else if (!any_unk || (pred_indep_in && !any_pm)) begin
              l_fwd <= 1'b0;
              l_spec_early <= any_unk;
              array_rd_out <= 1'b1;
              state <= ST_LAT;
            end else begin
              state <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          // RL1 fault once no longer speculative
          if (!ld_spec_in && l_flt) begin
            ld_fault_out <= 1'b1;
            state <= ST_IDLE;
          end else if ((!l_cw || !sb_val[l_src]) && !any_unk && !ld_spec_in) begin
            l_fwd <= 1'b0;
            l_spec_early <= 1'b0;
            array_rd_out <= 1'b1;
            state <= ST_LAT;
          end
        end
        ST_LAT: begin
          if (lat <= 4'h1) begin
            state <= ST_IDLE;
            ld_done_out <= 1'b1;
            ld_fwd_out <= l_fwd;
            ld_data_out <= l_data;
            // RL20 verify and replay
            if (l_spec_early && (|(sb_av & sb_val))) begin
              for (j = 0; j < 8; j = j + 1) begin
                if (sb_av[j] && sb_val[j] && (l_addr < sb_lin[j] + {26'h0, sb_size[j]})
                  && (sb_lin[j] < l_addr + {26'h0, l_size})) ld_replay_out <= 1'b1;
              end
            end
          end else begin
            lat <= lat - 4'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // lsfd_unit
`default_nettype wire

/* File: rtl/lsfd_xlat.v */
// Purpose: Two-level data address translation, tag lookup only
// Assumes: Fills come from the page walker port
// Notes: Three lookups per cycle; second level reports in the same cycle as the first
`default_nettype none
module lsfd_xlat (
  input wire clk_in,
  input wire sys_rst_in,
  input wire [2:0] req_in,
  input wire [59:0] vpn_in,
  input wire fill_in,
  input wire [19:0] fill_vpn_in,
  input wire [1:0] fill_pg_in,
  output reg [2:0] hit_out,
  output reg [2:0] l2hit_out
);
  // Tags kept as page numbers; first-level size classes, second-level 4K
  reg [19:0] tag4k [0:63];
  reg [19:0] tag2m [0:31];
  reg [19:0] tag1g [0:3];
  reg [19:0] tagl2 [0:511];
  reg [63:0] v4k;
  reg [31:0] v2m;
  reg [3:0] v1g;
  reg [511:0] vl2;
  reg [1:0] rr;
  reg [2:0] h1;
  reg [2:0] h2;
  integer p;
  integer w;
  reg [19:0] vp;
  always @* begin
    h1 = 3'h0;
    h2 = 3'h0;
    vp = 20'h00000;
    // RL7 three lookups per cycle
    for (p = 0; p < 3; p = p + 1) begin
      vp = vpn_in[p*20 +: 20];
      // RL9 RL10 four ways per page class
      for (w = 0; w < `LSFD_WAYS; w = w + 1) begin
        if (v4k[vp[3:0]*4+w] && tag4k[vp[3:0]*4+w] == vp) h1[p] = 1'b1;
        if (v2m[vp[11:9]*4+w] && tag2m[vp[11:9]*4+w][19:9] == vp[19:9]) h1[p] = 1'b1;
        if (v1g[w] && tag1g[w][19:18] == vp[19:18]) h1[p] = 1'b1;
        if (vl2[vp[6:0]*4+w] && tagl2[vp[6:0]*4+w] == vp) h2[p] = 1'b1;
      end
    end
  end
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      v4k <= 64'h0;
      v2m <= 32'h0;
      v1g <= 4'h0;
      vl2 <= 512'h0;
      rr <= 2'h0;
      hit_out <= 3'h0;
      l2hit_out <= 3'h0;
    end else begin
      hit_out <= h1 & req_in;
      // RL8 second level on first miss
      l2hit_out <= ~h1 & h2 & req_in;
      if (fill_in) begin
        rr <= rr + 2'h1;
        if (fill_pg_in == `LSFD_PG_4K) begin
          v4k[fill_vpn_in[3:0]*4+rr] <= 1'b1;
          tag4k[fill_vpn_in[3:0]*4+rr] <= fill_vpn_in;
          vl2[fill_vpn_in[6:0]*4+rr] <= 1'b1;
          tagl2[fill_vpn_in[6:0]*4+rr] <= fill_vpn_in;
        end else if (fill_pg_in == `LSFD_PG_2M) begin
          v2m[fill_vpn_in[11:9]*4+rr] <= 1'b1;
          tag2m[fill_vpn_in[11:9]*4+rr] <= fill_vpn_in;
        end else begin
          v1g[rr] <= 1'b1;
          tag1g[rr] <= fill_vpn_in;
        end
      end
    end
  end
endmodule // lsfd_xlat
`default_nettype wire

/* File: shared/lsfd_defines.vh */
// Purpose: Constants for the load/store forwarding and disambiguation unit
// Assumes: 20 MHz core clock, byte addressing
// Notes: Sizes are byte counts; latencies are clock cycles
`ifndef LSFD_DEFINES_VH
`define LSFD_DEFINES_VH
`define LSFD_AW 32
`define LSFD_SB_DEPTH 8
`define LSFD_SB_IDXW 3
`define LSFD_SHORT_OFS 12'h800
`define LSFD_DT_INT 2'h0
`define LSFD_DT_VEC128 2'h1
`define LSFD_DT_STACK 2'h2
`define LSFD_DT_VEC256 2'h3
`define LSFD_LAT_INT 4'h5
`define LSFD_LAT_VEC128 4'h6
`define LSFD_LAT_STACK 4'h7
`define LSFD_LAT_VEC256 4'h7
`define LSFD_LAT_SEG 4'h1
`define LSFD_L2X_PENALTY 4'h7
`define LSFD_COMMIT_BYTES 6'h10
`define LSFD_PG_4K 2'h0
`define LSFD_PG_2M 2'h1
`define LSFD_PG_1G 2'h2
`define LSFD_L1X_SETS_4K 16
`define LSFD_L1X_SETS_2M 8
`define LSFD_L1X_SETS_1G 1
`define LSFD_L2X_SETS 128
`define LSFD_WAYS 4
`define LSFD_DIS_BITS 12
`endif

/* File: tb/lsfd_core_model.sv */
// Purpose: Execution-core stand-in that issues loads and stores to the unit
// Assumes: Requests change just after rising edges; loads hold until taken, store phases last one cycle
// Notes: Ports carry the unit's input names so the bench joins them by name
`default_nettype none
module lsfd_core_model (
  input wire logic clk_in,
  input wire logic ld_ready_out,
  output var logic st_alloc_in,
  output var logic st_addr_in,
  output var logic [2:0] st_addr_idx_in,
  output var logic [31:0] st_lin_in,
  output var logic [31:0] st_phys_in,
  output var logic [5:0] st_size_in,
  output var logic st_nt_in,
  output var logic st_data_in,
  output var logic [2:0] st_data_idx_in,
  output var logic [255:0] st_wdata_in,
  output var logic st_retire_in,
  output var logic ld_valid_in,
  output var logic [31:0] ld_addr_in,
  output var logic [5:0] ld_size_in,
  output var logic [1:0] ld_type_in,
  output var logic ld_short_in,
  output var logic [11:0] ld_ofs_in,
  output var logic ld_seg_nz_in,
  output var logic ld_wb_in,
  output var logic ld_nt_in,
  output var logic ld_spec_in,
  output var logic ld_fault_in,
  output var logic ld_uc_in,
  output var logic pred_indep_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {st_alloc_in, st_addr_in, st_addr_idx_in, st_lin_in, st_phys_in, st_size_in, st_nt_in, st_data_in} = '0;
    {st_data_idx_in, st_wdata_in, st_retire_in, ld_valid_in, ld_addr_in, ld_size_in, ld_type_in} = '0;
    {ld_short_in, ld_ofs_in, ld_seg_nz_in, ld_wb_in, ld_nt_in, ld_spec_in, ld_fault_in, ld_uc_in, pred_indep_in} = '0;
  end
  // Phases picked by m: bit 0 allocate, bit 1 address, bit 2 data
  task automatic st_op(input logic [2:0] i, input logic [31:0] a, input logic [5:0] s, input logic [255:0] w,
                       input logic [2:0] m);
    @(posedge clk_in);
    st_alloc_in <= m[0];
    @(posedge clk_in);
    st_alloc_in <= 1'b0;
    st_addr_in <= m[1];
    {st_addr_idx_in, st_lin_in, st_phys_in, st_size_in} <= {i, a, a ^ 32'hF000_0000, s};
    @(posedge clk_in);
    st_addr_in <= 1'b0;
    st_data_in <= m[2];
    {st_data_idx_in, st_wdata_in} <= {i, w};
    @(posedge clk_in);
    st_data_in <= 1'b0;
    {st_phys_in, st_wdata_in} <= {~a, ~w};
  endtask
  // Flags f: short, segment, speculative, fault, uncached, predicted independent
  task automatic load(input logic [31:0] a, input logic [5:0] s, input logic [1:0] t, input logic [5:0] f);
    @(posedge clk_in);
    ld_valid_in <= 1'b1;
    {ld_addr_in, ld_size_in, ld_type_in, ld_ofs_in} <= {a, s, t, ~f[0], a[10:0]};
    {pred_indep_in, ld_uc_in, ld_fault_in, ld_spec_in, ld_seg_nz_in, ld_short_in} <= f;
    {ld_wb_in, ld_nt_in} <= 2'h2;
    @(negedge clk_in);
    while (ld_ready_out !== 1'b1) @(negedge clk_in);
    @(posedge clk_in);
    ld_valid_in <= 1'b0;
    ld_addr_in <= ~a;
  endtask
endmodule // lsfd_core_model
`default_nettype wire

/* File: tb/lsfd_unit_props.sv */
// Purpose: Port-level checks for the load/store unit
// Assumes: One clock, synchronous active-high reset
// Notes: Latency is judged only while no store was allocated since reset
`default_nettype none
module lsfd_unit_props (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic st_alloc_in,
  input wire logic ld_valid_in,
  input wire logic ld_ready_out,
  input wire logic [1:0] ld_type_in,
  input wire logic ld_short_in,
  input wire logic ld_seg_nz_in,
  input wire logic ld_wb_in,
  input wire logic ld_nt_in,
  input wire logic ld_spec_in,
  input wire logic ld_fault_in,
  input wire logic ld_uc_in,
  input wire logic pred_indep_in,
  input wire logic ld_done_out,
  input wire logic ld_fwd_out,
  input wire logic ld_fault_out,
  input wire logic ld_replay_out,
  input wire logic array_rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cl, uq, pq, nq, wq, bq;
  logic [3:0] cnt, lat;
  wire take = ld_valid_in && ld_ready_out;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      cl <= 1'b1;
      cnt <= 4'h0;
    end else begin
      cl <= cl && !st_alloc_in;
      cnt <= take ? 4'h1 : cnt + 4'h1;
      if (take) begin
        lat <= (ld_type_in == 2'h0 ? 4'h5 : ld_type_in == 2'h1 ? 4'h6 : 4'h7)
               - {3'h0, ld_short_in && ld_type_in != 2'h3} + {3'h0, ld_seg_nz_in};
        {uq, pq, nq, wq, bq} <= {ld_uc_in, pred_indep_in, ld_nt_in, ld_wb_in, ld_spec_in | ld_fault_in | ld_uc_in};
      end
    end
  end
  property p_lat;
    ld_done_out && cl && !bq |-> cnt == lat;
  endproperty
  a_lat: assert property (p_lat) else $error("load latency off");
  property p_one;
    take |=> !ld_ready_out;
  endproperty
  a_one: assert property (p_one) else $error("second load accepted in flight");
  property p_rd;
    take && cl && !ld_spec_in |=> array_rd_out;
  endproperty
  a_rd: assert property (p_rd) else $error("free load did not read array");
  property p_flt;
    ld_fault_out |-> !$past(ld_spec_in);
  endproperty
  a_flt: assert property (p_flt) else $error("fault while speculative");
  property p_uc;
    array_rd_out |-> !(uq && $past(ld_spec_in));
  endproperty
  a_uc: assert property (p_uc) else $error("speculative uncached read");
  property p_fwd;
    ld_fwd_out |-> ld_done_out && !nq && wq;
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward on wrong memory kind");
  property p_rep;
    ld_replay_out |-> ld_done_out && pq;
  endproperty
  a_rep: assert property (p_rep) else $error("replay of unpredicted load");
  property p_cln;
    ld_done_out && cl |-> !ld_fwd_out && !ld_replay_out;
  endproperty
  a_cln: assert property (p_cln) else $error("forward or replay with no store");
endmodule // lsfd_unit_props
bind lsfd_unit lsfd_unit_props u_props (.*);
`default_nettype wire

/* File: tb/tb_lsfd_unit.sv */
// Purpose: Self-checking bench for the load/store unit
// Assumes: 20 MHz clock, synchronous reset held two cycles
// Notes: Translation inputs stay idle outside the translation test
`default_nettype none
module tb_lsfd_unit;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic fwd; logic flt; logic rep; logic dchk; logic [31:0] d;} lsfd_exp_t;
  lsfd_exp_t expq[$];
  lsfd_exp_t ex;
  int miscompares, comparisons, n;
  logic clk_in, sys_rst_in, st_alloc_in, st_addr_in, st_nt_in, st_data_in, st_retire_in, ld_valid_in;
  logic ld_short_in, ld_seg_nz_in, ld_wb_in, ld_nt_in, ld_spec_in, ld_fault_in, ld_uc_in, pred_indep_in;
  logic [2:0] st_addr_idx_in, st_data_idx_in;
  logic [31:0] st_lin_in, st_phys_in, ld_addr_in, a, b;
  logic [5:0] st_size_in, ld_size_in;
  logic [255:0] st_wdata_in, w, w0;
  logic [1:0] ld_type_in;
  logic [11:0] ld_ofs_in;
  logic [15:0] f4 = 16'h1F1F;
  logic fill_in = 1'b0;
  logic [1:0] ld2_xlat_in = 2'h0, fill_pg_in = 2'h0;
  logic [19:0] fill_vpn_in = 20'h0;
  logic [59:0] xlat_vpn_in = 60'h0;
  wire ld_ready_out, ld_done_out, ld_fwd_out, ld_fault_out, ld_replay_out, array_rd_out, commit_out, sb_full_out;
  wire [255:0] ld_data_out;
  wire [31:0] commit_addr_out;
  wire [127:0] commit_data_out;
  wire [15:0] commit_be_out;
  wire [2:0] xlat_hit_out, xlat_l2hit_out;
  lsfd_unit u_dut (.*);
  lsfd_core_model u_core (.*);
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  task automatic push(input logic f, input logic t, input logic r, input logic c, input logic [31:0] d);
    expq.push_back({f, t, r, c, d});
  endtask
  task automatic conclude;
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic fin(input string t);
    for (int i = 0; i < 60 && expq.size() > 0; i++) @(posedge clk_in);
    chk("outstanding results", 0, expq.size());
    $display("test %s done", t);
  endtask
  task automatic do_reset;
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    u_core.st_retire_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
  endtask
  always @(negedge clk_in) begin
    if (sys_rst_in === 1'b0 && (ld_done_out === 1'b1 || ld_fault_out === 1'b1)) begin
      if (expq.size() == 0) begin
        chk("unrequested result", 0, 1);
      end else begin
        ex = expq.pop_front();
        chk("forward flag", ex.fwd, ld_fwd_out);
        chk("fault flag", ex.flt, ld_fault_out);
        chk("replay flag", ex.rep, ld_replay_out);
        if (ex.dchk) chk("load data", ex.d, ld_data_out[31:0]);
      end
    end
  end
  initial begin
    repeat (4000) @(posedge clk_in);
    miscompares++;
    conclude;
  end
  initial begin
    sys_rst_in = 1'b1;
    void'($urandom(27827));
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      push(0, 0, 0, 0, 0);
      u_core.load($urandom & 32'h7FFF_FFE0, 6'h08 << (i % 4 == 1 ? 1 : i % 4 == 3 ? 2 : 0), i[1:0], {4'h0, i[3], i[2]});
    end
    fin("latency");
    do_reset;
    w0 = {128'h0, $urandom, $urandom, $urandom, $urandom};
    w = {128'h0, $urandom, $urandom, $urandom, $urandom};
    a = ($urandom & 32'h0000_7FF0) | 32'h0001_0000;
    u_core.st_op(3'h0, a, 6'h10, w0, 3'h7);
    u_core.st_op(3'h1, a, 6'h10, w, 3'h7);
    for (int j = 0; j < 18; j++) begin
      b = (j < 16) ? j : (j - 16) * 8;
      if (j > 15 || f4[j % 16]) begin
        push(1, 0, 0, 1, 32'(w >> (8 * b)));
        u_core.load(a + b, (j < 16) ? 6'h04 : 6'h08, 2'h0, 6'h0);
      end
    end
    push(0, 0, 0, 0, 0);
    u_core.load(a + 13, 6'h04, 2'h0, 6'h0);
    n = 0;
    for (int c = 0; c < 15; c++) begin
      @(negedge clk_in);
      n = n + (commit_out === 1'b1);
    end
    chk("commits before retire", 0, n);
    chk("held load", 1, expq.size());
    @(posedge clk_in);
    u_core.st_retire_in <= 1'b1;
    for (int c = 0; c < 40 && n < 2; c++) begin
      @(negedge clk_in);
      if (commit_out === 1'b1) begin
        chk("commit address", a ^ 32'hF000_0000, commit_addr_out);
        chk("commit data", n ? w[31:0] : w0[31:0], commit_data_out[31:0]);
        chk("commit bytes", 32'hFFFF, commit_be_out);
        n++;
      end
    end
    chk("commit count", 2, n);
    fin("forwarding");
    do_reset;
    for (int i = 0; i < 2; i++) begin
      push(0, i[0], 0, 0, 0);
      u_core.load($urandom & 32'h7FFF_FFF8, 6'h08, 2'h0, i ? 6'h0C : 6'h14);
      repeat (20) @(posedge clk_in);
      chk("speculative load held", 1, expq.size());
      u_core.ld_spec_in <= 1'b0;
      fin("speculative");
    end
    do_reset;
    a = ($urandom & 32'h0000_7F00) | 32'h0002_0000;
    u_core.st_op(3'h0, a, 6'h08, w, 3'h1);
    push(0, 0, 0, 0, 0);
    u_core.load(a + 14, 6'h04, 2'h0, 6'h20);
    repeat (10) @(posedge clk_in);
    chk("split load held", 1, expq.size());
    u_core.st_op(3'h0, a + 32'h100, 6'h08, w, 3'h2);
    fin("split stall");
    push(0, 0, 1, 0, 0);
    u_core.st_op(3'h1, a + 32'h40, 6'h08, w, 3'h1);
    u_core.load(a + 32'h40, 6'h08, 2'h0, 6'h20);
    u_core.st_op(3'h1, a + 32'h40, 6'h08, w, 3'h2);
    fin("replay");
    do_reset;
    for (int q = 0; q < 8; q++) u_core.st_op(q[2:0], a, 6'h08, w, 3'h1);
    @(negedge clk_in);
    chk("buffer full", 1, sb_full_out);
    b = $urandom;
    // Fifth fill shares the first-level set and evicts the first page there
    for (int q = 0; q < 5; q++) begin
      @(posedge clk_in);
      {fill_in, fill_vpn_in, fill_pg_in} <= {1'b1, b[19:0] + 20'(q * 16), 2'h0};
    end
    @(posedge clk_in);
    {fill_in, ld2_xlat_in, xlat_vpn_in} <= {1'b0, 2'h3, 20'h0, b[19:0] + 20'h00040, b[19:0]};
    repeat (2) @(negedge clk_in);
    chk("first level hits", 3'h2, xlat_hit_out);
    chk("second level hits", 3'h1, xlat_l2hit_out);
    @(posedge clk_in);
    ld2_xlat_in <= 2'h0;
    fin("translation");
    conclude;
  end
endmodule // tb_lsfd_unit
`default_nettype wire
